/* verilog/flash_ctrl_host.sv */
// CPU end: turns software commands into link accesses and keeps the software-side discipline.
`timescale 1ns/1ps
module flash_ctrl_host
  import flash_pkg::*;
#(
  parameter int UNITS         = 16,
  parameter int MAX_REPEAT    = 1000,
  parameter int STBY_MIN_CYC  = STBY_WAKE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [2:0]  sw_addr_i,
  input  wire logic [31:0] sw_wdata_i,
  input  wire logic        sw_wr_i,
  input  wire logic        sw_rd_i,
  output logic [31:0]      sw_rdata_o,
  input  wire logic        exc_start_i,
  input  wire logic        sleep_i,
  input  wire logic        bus_release_i,
  input  wire logic        standby_req_i,
  flash_link_if.cpu        link
);
  if (UNITS < 1 || UNITS > 16 || MAX_REPEAT < 1 || MAX_REPEAT > 65535) begin : g_bad_cfg
    $error("flash_ctrl_host: unsupported parameters");
  end

  host_state_e     state_q;
  logic [15:0]     addr_q, wdt_per_q, wdt_cnt_q, rep_q, wake_q;
  logic [31:0]     data_q, rdata_q;
  logic [7:0]      buf_q [UNIT_BYTES];
  logic [6:0]      ptr_q, idx_q;
  logic [3:0]      stby_sel_q;
  logic [15:0]     ebs_q, done_q;
  logic            refused_q, wdt_fired_q, rd_pend_q, stby_q;
  logic            acc_wr_q, acc_rd_q, acc_flash_q;
  logic [15:0]     acc_addr_q;
  logic [7:0]      acc_wdata_q;
  logic [2:0]      op;
  logic [7:0]      byte_v, new_ebs;
  logic            cmd, ok, stby_ok;
  logic [3:0]      unit_ix;

  function automatic logic over_one(input logic [15:0] v);
    return (v & (v - 16'h0001)) != 16'h0000;
  endfunction

  assign op      = sw_wdata_i[2:0];
  assign byte_v  = sw_wdata_i[15:8];
  assign cmd     = sw_wr_i && sw_addr_i == HREG_CMD && state_q == H_IDLE;
  assign unit_ix = 4'(addr_q[15:7] % 9'(UNITS));
  assign new_ebs = byte_v;
  // RQ21 enough wake wait chosen
  assign stby_ok = 32'(stby_sel_q) * STBY_STEP_CYC >= STBY_MIN_CYC;

  always_comb begin
    ok = 1'b1;
    if (op == OP_REGWR && addr_q[1:0] == REG_FC1 && (byte_v[FC1_PGM] || byte_v[FC1_ERS])) begin
      // RQ10 repetition limit
      ok = rep_q < 16'(MAX_REPEAT);
    end else if (op == OP_REGWR && addr_q[1:0] == REG_EBS1) begin
      // RQ9 single block bit
      ok = !over_one({ebs_q[15:8], new_ebs});
    end else if (op == OP_REGWR && addr_q[1:0] == REG_EBS2) begin
      ok = !over_one({new_ebs, ebs_q[7:0]});
    end else if (op == OP_UNIT) begin
      // RQ3 aligned start, RQ8 no reprogram
      ok = addr_q[6:0] == 7'h00 && !done_q[unit_ix];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= H_IDLE;
      idx_q <= 7'h00;
      wake_q <= 16'h0000;
    end else begin
      case (state_q)
        H_IDLE: begin
          if (stby_q) begin
            state_q <= H_WAKE;
            wake_q <= 16'(stby_sel_q) * 16'(STBY_STEP_CYC);
          end else if (cmd && op == OP_UNIT && ok) begin
            state_q <= H_STREAM;
            idx_q <= 7'h00;
          end
        end
        H_STREAM: begin
          idx_q <= idx_q + 7'h01;
          if (idx_q == 7'(UNIT_BYTES - 1)) state_q <= H_IDLE;
        end
        H_WAKE: begin
          if (!stby_q && wake_q == 16'h0000) state_q <= H_IDLE;
          else if (!stby_q) wake_q <= wake_q - 16'h0001;
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // Link access generation.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acc_wr_q <= 1'b0;
      acc_rd_q <= 1'b0;
      acc_flash_q <= 1'b0;
      acc_addr_q <= 16'h0000;
      acc_wdata_q <= 8'h00;
    end else begin
      acc_wr_q <= 1'b0;
      acc_rd_q <= 1'b0;
      if (state_q == H_STREAM) begin
        // RQ2 full unit streamed
        acc_wr_q <= 1'b1;
        acc_flash_q <= 1'b1;
        acc_addr_q <= addr_q + 16'(idx_q);
        acc_wdata_q <= buf_q[idx_q];
      end else if (cmd && ok) begin
        acc_flash_q <= op != OP_REGWR && op != OP_REGRD;
        acc_wr_q <= op == OP_REGWR || op == OP_DUMMY;
        acc_rd_q <= op == OP_REGRD || op == OP_FREAD;
        // RQ6 RQ7 dummy write FF aligned
        acc_addr_q <= (op == OP_DUMMY || op == OP_FREAD) ? {addr_q[15:2], 2'b00} : addr_q;
        acc_wdata_q <= (op == OP_DUMMY) ? FILL_BYTE : byte_v;
      end
    end
  end

  // Unit buffer refills with FF as it drains so short units are padded.
  always_ff @(posedge clk_i) begin
    if (state_q == H_STREAM) buf_q[idx_q] <= FILL_BYTE;
    else if (sw_wr_i && sw_addr_i == HREG_BUF) buf_q[ptr_q] <= sw_wdata_i[7:0];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_q <= 16'h0000;
      ptr_q <= 7'h00;
      wdt_per_q <= 16'hFFFF;
      stby_sel_q <= 4'h0;
      refused_q <= 1'b0;
      rep_q <= 16'h0000;
      ebs_q <= 16'h0000;
      done_q <= 16'h0000;
    end else begin
      if (sw_wr_i && sw_addr_i == HREG_ADDR) addr_q <= sw_wdata_i[15:0];
      if (sw_wr_i && sw_addr_i == HREG_WDT) wdt_per_q <= sw_wdata_i[15:0];
      if (sw_wr_i && sw_addr_i == HREG_STBY) stby_sel_q <= sw_wdata_i[3:0];
      if (sw_wr_i && sw_addr_i == HREG_BUF) ptr_q <= ptr_q + 7'h01;
      if (state_q == H_STREAM && idx_q == 7'(UNIT_BYTES - 1)) done_q[unit_ix] <= 1'b1;
      if (cmd && !ok) refused_q <= 1'b1;
      else if (sw_wr_i && sw_addr_i == HREG_STAT && sw_wdata_i[0]) refused_q <= 1'b0;
      if (cmd && ok && op == OP_UNIT) rep_q <= 16'h0000;
      if (cmd && ok && op == OP_REGWR) begin
        // RQ11 count erase and program pulses
        if (addr_q[1:0] == REG_FC1 && (byte_v[FC1_PGM] || byte_v[FC1_ERS])) rep_q <= rep_q + 16'h0001;
        if (addr_q[1:0] == REG_EBS1) ebs_q[7:0] <= new_ebs;
        if (addr_q[1:0] == REG_EBS2) ebs_q[15:8] <= new_ebs;
        if (addr_q[1:0] == REG_EBS1 || addr_q[1:0] == REG_EBS2) rep_q <= 16'h0000;
        if (addr_q[1:0] == REG_FC1 && byte_v[FC1_ERS]) done_q <= done_q & ~ebs_q;
      end
    end
  end

  // RQ12 watchdog armed per pulse
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wdt_cnt_q <= 16'h0000;
      wdt_fired_q <= 1'b0;
    end else if (cmd && ok && op == OP_REGWR && addr_q[1:0] == REG_FC1 && (byte_v[FC1_PGM] || byte_v[FC1_ERS])) begin
      wdt_cnt_q <= wdt_per_q;
    end else if (wdt_cnt_q != 16'h0000 && link.flash_busy) begin
      wdt_cnt_q <= wdt_cnt_q - 16'h0001;
      if (wdt_cnt_q == 16'h0001) wdt_fired_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_pend_q <= 1'b0;
      data_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      stby_q <= 1'b0;
    end else begin
      rd_pend_q <= acc_rd_q;
      if (rd_pend_q) data_q <= link.acc_rdata;
      stby_q <= standby_req_i & stby_ok & state_q != H_STREAM;
      case (sw_addr_i)
        HREG_CMD:  rdata_q <= {30'h0, state_q};
        HREG_ADDR: rdata_q <= {16'h0000, addr_q};
        HREG_DATA: rdata_q <= data_q;
        HREG_STAT: rdata_q <= {27'h0, link.irq_block, link.flash_busy, stby_q, wdt_fired_q, refused_q};
        HREG_WDT:  rdata_q <= {16'h0000, wdt_per_q};
        HREG_STBY: rdata_q <= {28'h0, stby_sel_q};
        default:   rdata_q <= 32'h0000_0000;
      endcase
      if (!sw_rd_i) rdata_q <= 32'h0000_0000;
    end
  end

  assign sw_rdata_o       = rdata_q;
  assign link.acc_wr      = acc_wr_q;
  assign link.acc_rd      = acc_rd_q;
  assign link.acc_flash   = acc_flash_q;
  assign link.acc_addr    = acc_addr_q;
  assign link.acc_wdata   = acc_wdata_q;
  assign link.exc_start   = exc_start_i;
  assign link.sleep_exec  = sleep_i;
  assign link.bus_release = bus_release_i;
  assign link.standby     = stby_q;
  assign link.wdt_reset   = wdt_cnt_q == 16'h0001 && link.flash_busy;
endmodule

/* shared/flash_pkg.sv */
// Shared constants and types for the flash program/erase controller and its CPU end.
package flash_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STBY_WAKE_NS  = 100000;
  localparam int STBY_WAKE_CYC = (STBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STBY_STEP_CYC = 1024;
  // ----------------------------------------------------------------
  // Device register map (register index on the link)
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_FC1  = 2'h0;
  localparam logic [1:0] REG_FC2  = 2'h1;
  localparam logic [1:0] REG_EBS1 = 2'h2;
  localparam logic [1:0] REG_EBS2 = 2'h3;
  localparam int FC1_PGM = 0;
  localparam int FC1_ERS = 1;
  localparam int FC1_PV  = 2;
  localparam int FC1_EV  = 3;
  localparam int FC1_WEG = 6;
  localparam int FC2_ERR = 7;
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [7:0] FILL_BYTE  = 8'hFF;
  localparam int         UNIT_BYTES = 128;
  localparam int         ADDR_W     = 16;
  // ----------------------------------------------------------------
  // Host register map and commands
  // ----------------------------------------------------------------
  localparam logic [2:0] HREG_CMD  = 3'h0;
  localparam logic [2:0] HREG_ADDR = 3'h1;
  localparam logic [2:0] HREG_DATA = 3'h2;
  localparam logic [2:0] HREG_STAT = 3'h3;
  localparam logic [2:0] HREG_WDT  = 3'h4;
  localparam logic [2:0] HREG_STBY = 3'h5;
  localparam logic [2:0] HREG_BUF  = 3'h6;
  localparam logic [2:0] OP_REGWR  = 3'h1;
  localparam logic [2:0] OP_REGRD  = 3'h2;
  localparam logic [2:0] OP_UNIT   = 3'h3;
  localparam logic [2:0] OP_DUMMY  = 3'h4;
  localparam logic [2:0] OP_FREAD  = 3'h5;
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000,
    MODE_PGM  = 3'b001,
    MODE_ERS  = 3'b010,
    MODE_PV   = 3'b011,
    MODE_EV   = 3'b100
  } flash_mode_e;
  typedef enum logic [1:0] {
    H_IDLE   = 2'b00,
    H_STREAM = 2'b01,
    H_WAKE   = 2'b10
  } host_state_e;
endpackage

/* shared/flash_link_if.sv */
// Link between the CPU end and the flash program/erase controller.
`timescale 1ns/1ps
interface flash_link_if;
  logic        acc_wr;
  logic        acc_rd;
  logic        acc_flash;
  logic [15:0] acc_addr;
  logic [7:0]  acc_wdata;
  logic [31:0] acc_rdata;
  logic        exc_start;
  logic        sleep_exec;
  logic        bus_release;
  logic        standby;
  logic        wdt_reset;
  logic        flash_busy;
  logic        irq_block;
  modport dev (input acc_wr, acc_rd, acc_flash, acc_addr, acc_wdata, exc_start, sleep_exec,
               bus_release, standby, wdt_reset, output acc_rdata, flash_busy, irq_block);
  modport cpu (output acc_wr, acc_rd, acc_flash, acc_addr, acc_wdata, exc_start, sleep_exec,
               bus_release, standby, wdt_reset, input acc_rdata, flash_busy, irq_block);
endinterface

/* verilog/flash_ctrl_dev.sv */
// Flash program/erase controller with its array, unit latch and protection logic.
// How it works
// RQ1 - One of program, erase, verify modes
// RQ2 - Software sends full units padded with FF
// RQ3 - Latch address and 128 bytes; aligned start
// RQ4 - Program only while program request held
// RQ5 - Erase only while erase request held
// RQ6 - Dummy write, then word verify reads
// RQ7 - Dummy write, then longword erase-verify reads
// RQ8 - Never program an address twice before erase
// RQ9 - Exactly one erase block bit per erase; the host only refuses more than one, so an erase with none selected goes ahead
// RQ10 - Bounded program and verify repetitions
// RQ11 - Bounded erase and verify repetitions
// RQ12 - Arm watchdog before each pulse
// RQ13 - Block all interrupts while busy or booting
// RQ14 - Reset or standby aborts and clears registers
// RQ15 - Write gate low blocks program and erase
// RQ16 - Unselected blocks are erase protected
// RQ17 - Illegal events while busy set error flag
// RQ18 - Error keeps registers, aborts, blocks re-entry
// RQ19 - Only reset or standby leave error state
// RQ20 - Readable when active, halted in standby
// RQ21 - Standby wake wait at least 100 us
// RQ22 - Gate high: reads only in verify modes
// RQ23 - Ignore writes setting several mode bits
`timescale 1ns/1ps
module flash_ctrl_dev
  import flash_pkg::*;
#(
  parameter int ARRAY_BYTES = 2048,
  parameter int BLOCKS      = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  flash_link_if.dev        link,
  input  wire logic        boot_running_i,
  output logic [2:0]       mode_o,
  output logic             error_o
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int BLK_BYTES = ARRAY_BYTES / BLOCKS;
  localparam int AW        = $clog2(ARRAY_BYTES);

  if (BLOCKS < 1 || BLOCKS > 16 || ARRAY_BYTES % BLOCKS != 0 || BLK_BYTES % UNIT_BYTES != 0
      || ARRAY_BYTES > (1 << ADDR_W)) begin : g_bad_cfg
    $error("flash_ctrl_dev: unsupported array geometry");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]     fc1_q;
  logic [7:0]     ebs1_q;
  logic [7:0]     ebs2_q;
  logic           err_q;
  logic [7:0]     mem [ARRAY_BYTES];
  logic [7:0]     unit_q [UNIT_BYTES];
  logic [AW-1:0]  unit_base_q;
  logic [7:0]     unit_cnt_q;
  logic [31:0]    rdata_q;
  flash_mode_e    mode;
  logic           busy;
  logic           hw_clear;
  logic           err_evt;
  logic           reg_wr;
  logic           flash_wr;
  logic           flash_rd;
  logic [15:0]    blk_sel;
  logic [AW-1:0]  rd_addr;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic flash_mode_e decode_mode(input logic [7:0] fc1, input logic err);
    flash_mode_e m;
    m = MODE_IDLE;
    // RQ15 gate blocks entry
    if (fc1[FC1_WEG] && !err && fc1[FC1_PGM]) begin
      m = MODE_PGM;
    end else if (fc1[FC1_WEG] && !err && fc1[FC1_ERS]) begin
      m = MODE_ERS;
    end else if (fc1[FC1_PV]) begin
      m = MODE_PV;
    end else if (fc1[FC1_EV]) begin
      m = MODE_EV;
    end
    return m;
  endfunction

  function automatic logic many_bits(input logic [3:0] v);
    return (v & (v - 4'h1)) != 4'h0;
  endfunction

  // RQ1 single mode select
  assign mode     = decode_mode(fc1_q, err_q);
  assign busy     = (mode == MODE_PGM) || (mode == MODE_ERS);
  // RQ14 watchdog reset or standby
  assign hw_clear = link.wdt_reset | link.standby;
  assign reg_wr   = link.acc_wr & ~link.acc_flash & ~hw_clear;
  assign flash_wr = link.acc_wr & link.acc_flash & ~link.standby;
  assign flash_rd = link.acc_rd & link.acc_flash;
  assign blk_sel  = {ebs2_q, ebs1_q};
  assign rd_addr  = link.acc_addr[AW-1:0];

  // RQ17 illegal events while busy
  assign err_evt = busy & (flash_rd | link.exc_start | link.sleep_exec | link.bus_release);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fc1_q <= REG_RST;
    end else if (hw_clear) begin
      // RQ14 clear on abort
      fc1_q <= REG_RST;
    end else if (reg_wr && link.acc_addr[1:0] == REG_FC1) begin
      // RQ23 reject several mode bits
      if (!many_bits(link.acc_wdata[3:0])) begin
        fc1_q <= link.acc_wdata & 8'h4F;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ebs1_q <= REG_RST;
      ebs2_q <= REG_RST;
    end else if (hw_clear) begin
      // RQ14 clear block selects
      ebs1_q <= REG_RST;
      ebs2_q <= REG_RST;
    end else if (reg_wr && link.acc_addr[1:0] == REG_EBS1) begin
      ebs1_q <= link.acc_wdata;
    end else if (reg_wr && link.acc_addr[1:0] == REG_EBS2) begin
      ebs2_q <= link.acc_wdata;
    end
  end

  // The event wins over a simultaneous standby or watchdog clear, so a
  // fault in the last busy cycle is never lost.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_q <= 1'b0;
    end else begin
      // RQ19 only reset or standby clear
      err_q <= err_evt | (err_q & ~hw_clear);
    end
  end

  // ----------------------------------------------------------------
  // Program unit latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      unit_base_q <= '0;
      unit_cnt_q  <= 8'h00;
    end else if (hw_clear) begin
      unit_cnt_q <= 8'h00;
    end else if (flash_wr && mode == MODE_IDLE) begin
      // RQ3 latch address and bytes
      if (unit_cnt_q == 8'h00) begin
        unit_base_q <= rd_addr & ~AW'(UNIT_BYTES - 1);
      end
      unit_cnt_q <= (unit_cnt_q == 8'(UNIT_BYTES - 1)) ? 8'h00 : unit_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (flash_wr && mode == MODE_IDLE && !hw_clear) begin
      unit_q[link.acc_addr[6:0]] <= link.acc_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Array program and erase
  // ----------------------------------------------------------------
  // Each cycle of a held request is one slice of the pulse; the pulse
  // length is therefore the time the bit stays set, ending early if an illegal event is flagged.
  always_ff @(posedge clk_i) begin
    if (!hw_clear && !err_evt) begin
      if (mode == MODE_PGM) begin
        // RQ4 program while request held
        for (int j = 0; j < UNIT_BYTES; j++) begin
          mem[unit_base_q + AW'(j)] <= mem[unit_base_q + AW'(j)] & unit_q[j];
        end
      end else if (mode == MODE_ERS) begin
        // RQ5 erase while request held
        for (int i = 0; i < ARRAY_BYTES; i++) begin
          // RQ16 unselected blocks protected
          if (blk_sel[i / BLK_BYTES]) begin
            mem[i] <= FILL_BYTE;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (!link.acc_rd || link.standby) begin
      // RQ20 halted in standby
      rdata_q <= 32'h0000_0000;
    end else if (!link.acc_flash) begin
      case (link.acc_addr[1:0])
        REG_FC1:  rdata_q <= {24'h000000, fc1_q};
        REG_FC2:  rdata_q <= {24'h000000, err_q, 7'h00};
        REG_EBS1: rdata_q <= {24'h000000, ebs1_q};
        default:  rdata_q <= {24'h000000, ebs2_q};
      endcase
    end else begin
      case (mode)
        // RQ6 word verify read
        MODE_PV: rdata_q <= {16'h0000, mem[{rd_addr[AW-1:1], 1'b0}], mem[{rd_addr[AW-1:1], 1'b1}]};
        // RQ7 longword verify read
        MODE_EV: rdata_q <= {mem[{rd_addr[AW-1:2], 2'h0}], mem[{rd_addr[AW-1:2], 2'h1}],
                             mem[{rd_addr[AW-1:2], 2'h2}], mem[{rd_addr[AW-1:2], 2'h3}]};
        // RQ22 gate high hides array
        MODE_IDLE: rdata_q <= fc1_q[FC1_WEG] ? 32'h0000_0000 : {24'h000000, mem[rd_addr]};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.acc_rdata  = rdata_q;
  assign link.flash_busy = busy;
  // RQ13 block interrupts while busy
  assign link.irq_block  = busy | boot_running_i;
  assign mode_o          = mode;
  // RQ18 error keeps registers, blocks entry
  assign error_o         = err_q;
endmodule

/* verification/flash_link_sva.sv */
// Checker watching the link between the CPU end and the flash controller.
`timescale 1ns/1ps
module flash_link_sva
  import flash_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        acc_wr,
  input wire logic        acc_rd,
  input wire logic        acc_flash,
  input wire logic [15:0] acc_addr,
  input wire logic [7:0]  acc_wdata,
  input wire logic [31:0] acc_rdata,
  input wire logic        exc_start,
  input wire logic        sleep_exec,
  input wire logic        bus_release,
  input wire logic        standby,
  input wire logic        wdt_reset,
  input wire logic        flash_busy,
  input wire logic        irq_block
);
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence err_evt;
    flash_busy && (exc_start || sleep_exec || bus_release || (acc_rd && acc_flash));
  endsequence
  // Writes setting several mode bits are ignored, so they are kept out of the plain write.
  sequence fc1_wr;
    acc_wr && !acc_flash && acc_addr[1:0] == REG_FC1 && !standby && !wdt_reset && $countones(acc_wdata[3:0]) < 2;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_busy_irq_block: assert property (flash_busy |-> irq_block)
    else $error("interrupts not blocked while busy");
  a_standby_abort: assert property (standby |=> !flash_busy)
    else $error("standby did not abort the operation");
  a_wdt_abort: assert property (wdt_reset |=> !flash_busy)
    else $error("watchdog reset did not abort the operation");
  a_error_abort: assert property (err_evt |=> !flash_busy)
    else $error("illegal event did not abort the operation");
  a_error_hold: assert property (err_evt ##1 (!standby && !wdt_reset)[*4] |-> !flash_busy)
    else $error("operation re-entered in error protection");
  a_gate_off: assert property (fc1_wr ##0 !acc_wdata[6] |=> !flash_busy)
    else $error("operation started with the write gate low");
  a_request_clear: assert property (fc1_wr ##0 acc_wdata[1:0] == 2'b00 |=> !flash_busy)
    else $error("operation continued after its request cleared");
  a_multi_ignored: assert property (acc_wr && !acc_flash && acc_addr[1:0] == REG_FC1
    && acc_wdata[1:0] == 2'b11 && !flash_busy |=> !flash_busy) else $error("multi-bit mode write took effect");
  a_busy_read_zero: assert property (acc_rd && acc_flash && flash_busy |=> acc_rdata == 32'h0)
    else $error("array data visible while busy");
endmodule

/* verification/flash_program_erase_control_bench.sv */
// Self-checking bench for the flash controller and its CPU end joined by their link.
`timescale 1ns/1ps
module flash_program_erase_control_bench import flash_pkg::*;;
  // ----------------------------------------------------------------
  // Harness
  // ----------------------------------------------------------------
  logic        clk_i;
  logic        rst_b_i;
  logic [2:0]  sw_addr;
  logic [31:0] sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [31:0] sw_rdata;
  logic        stby_req;
  logic        boot;
  logic [2:0]  mode;
  logic        error;
  logic [31:0] v;
  int          miscompares;
  int          samples_checked;
  int          cycles;
  flash_link_if link ();
  flash_ctrl_dev flash_ctrl_dev_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link), .boot_running_i(boot),
    .mode_o(mode), .error_o(error));
  // Small repeat and wake figures keep the run short.
  flash_ctrl_host #(.MAX_REPEAT(3), .STBY_MIN_CYC(8)) flash_ctrl_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata),
    .exc_start_i(1'b0), .sleep_i(1'b0), .bus_release_i(1'b0), .standby_req_i(stby_req), .link(link));
  flash_link_sva flash_link_sva_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .acc_wr(link.acc_wr), .acc_rd(link.acc_rd),
    .acc_flash(link.acc_flash), .acc_addr(link.acc_addr), .acc_wdata(link.acc_wdata), .acc_rdata(link.acc_rdata),
    .exc_start(link.exc_start), .sleep_exec(link.sleep_exec), .bus_release(link.bus_release),
    .standby(link.standby), .wdt_reset(link.wdt_reset), .flash_busy(link.flash_busy), .irq_block(link.irq_block));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_i);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_i);
    sw_wr <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [31:0] exp, input bit cmp);
    @(posedge clk_i);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_i);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
    if (cmp) chk(v, exp);
  endtask
  task automatic cmd(input logic [2:0] op, input logic [15:0] a, input logic [7:0] b);
    int n;
    wr(HREG_ADDR, {16'h0000, a});
    wr(HREG_CMD, {16'h0000, b, 5'h00, op});
    n = 0;
    v = 32'h1;
    while (v[1:0] !== H_IDLE && n < 3000) begin
      rc(HREG_CMD, 32'h0, 1'b0);
      n++;
    end
    if (n == 3000) miscompares++;
  endtask
  task automatic dw(input logic [1:0] r, input logic [7:0] b);
    cmd(OP_REGWR, {14'h0000, r}, b);
  endtask
  task automatic dr(input logic [1:0] r, input logic [31:0] exp);
    cmd(OP_REGRD, {14'h0000, r}, 8'h00);
    rc(HREG_DATA, exp, 1'b1);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst_b_i = 1'b0;
    sw_addr = 3'h0;
    sw_wdata = 32'h0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    stby_req = 1'b0;
    boot = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rc(HREG_STAT, 32'h0, 1'b1);
    rc(HREG_WDT, 32'h0000FFFF, 1'b1);
    rc(3'h7, 32'h0, 1'b1);
    boot <= 1'b1;
    rc(HREG_STAT, 32'h10, 1'b1);
    boot <= 1'b0;
    dr(REG_FC1, 32'h0);
    dr(REG_FC2, 32'h0);
    dr(REG_EBS1, 32'h0);
    $display("test reset done");
    dw(REG_EBS1, 8'h02);
    dw(REG_FC1, 8'h01);
    chk(32'(mode), 32'(MODE_IDLE));
    dw(REG_FC1, 8'h42);
    chk(32'(mode), 32'(MODE_ERS));
    rc(HREG_STAT, 32'h18, 1'b1);
    dw(REG_FC1, 8'h40);
    dw(REG_FC1, 8'h43);
    dr(REG_FC1, 32'h40);
    dw(REG_FC1, 8'h48);
    chk(32'(mode), 32'(MODE_EV));
    cmd(OP_DUMMY, 16'h0080, 8'hFF);
    cmd(OP_FREAD, 16'h0080, 8'h00);
    rc(HREG_DATA, 32'hFFFFFFFF, 1'b1);
    $display("test erase done");
    dw(REG_FC1, 8'h40);
    for (int i = 0; i < 128; i++) wr(HREG_BUF, 32'(i));
    cmd(OP_UNIT, 16'h0080, 8'h00);
    dw(REG_FC1, 8'h41);
    chk(32'(mode), 32'(MODE_PGM));
    dw(REG_FC1, 8'h44);
    chk(32'(mode), 32'(MODE_PV));
    cmd(OP_DUMMY, 16'h0084, 8'hFF);
    cmd(OP_FREAD, 16'h0084, 8'h00);
    rc(HREG_DATA, 32'h00000405, 1'b1);
    $display("test program done");
    dw(REG_FC1, 8'h40);
    cmd(OP_UNIT, 16'h0081, 8'h00);
    rc(HREG_STAT, 32'h1, 1'b1);
    wr(HREG_STAT, 32'h1);
    cmd(OP_UNIT, 16'h0080, 8'h00);
    rc(HREG_STAT, 32'h1, 1'b1);
    wr(HREG_STAT, 32'h1);
    dw(REG_EBS1, 8'h03);
    rc(HREG_STAT, 32'h1, 1'b1);
    wr(HREG_STAT, 32'h1);
    $display("test refusal done");
    dw(REG_FC1, 8'h41);
    cmd(OP_FREAD, 16'h0100, 8'h00);
    rc(HREG_DATA, 32'h0, 1'b1);
    chk(32'(error), 32'h1);
    dr(REG_FC1, 32'h41);
    dw(REG_FC1, 8'h40);
    dw(REG_FC1, 8'h41);
    chk(32'(mode), 32'(MODE_IDLE));
    wr(HREG_STBY, 32'h1);
    stby_req <= 1'b1;
    repeat (4) @(posedge clk_i);
    rc(HREG_STAT, 32'h4, 1'b1);
    stby_req <= 1'b0;
    repeat (1100) @(posedge clk_i);
    chk(32'(error), 32'h0);
    dr(REG_FC1, 32'h0);
    $display("test error done");
    dw(REG_FC1, 8'h41);
    rc(HREG_STAT, 32'h1, 1'b1);
    wr(HREG_STAT, 32'h1);
    wr(HREG_WDT, 32'h5);
    dw(REG_EBS1, 8'h02);
    dw(REG_FC1, 8'h42);
    repeat (20) @(posedge clk_i);
    rc(HREG_STAT, 32'h2, 1'b1);
    dr(REG_FC1, 32'h0);
    dr(REG_EBS1, 32'h0);
    $display("test watchdog done");
    tally_and_finish;
  end
endmodule
